// ---- pop_seq.sv ----
// Behaviour
// - Order bit 0: converter off with amplifiers
// - Order bit 1: converter off after amplifiers
// - Four-bit code selects driver power-on delay
// - Power-on code resets to 304 ms
// - Two-bit code selects ramp step time
// - Ramp step code resets to 3.9 ms
// - All durations counted from internal oscillator
// - Common-mode from supply divider; 1 reserved
// - Three-bit code selects speaker power-up wait
// - Speaker wait code resets to zero
// - Left converter route: none, mixer, driver
// - Right converter route: none, mixer, driver
// - Voice input to left mixer when set
// - Extra line input to left mixer
// - Extra line input to right mixer
// - Left driver feeds right driver when set
`timescale 1ns/10ps
module pop_seq #(
  parameter int unsigned OSC_HZ_P   = 8_200_000,  // Oscillator rate, Hz
  parameter int unsigned TIME_DIV   = 1,          // Divides all tick counts
  parameter int unsigned RAMP_STEPS = 8           // Gain steps in one ramp
) (
  input  wire logic       clk_in,             // 200 MHz clock
  input  wire logic       rstn_in,            // Async reset, active low
  input  wire logic [7:0] reg_addr_in,        // Register offset
  input  wire logic [7:0] reg_wdata_in,       // Write data
  input  wire logic       reg_wr_in,          // Write strobe
  input  wire logic       reg_rd_in,          // Read strobe
  output logic      [7:0] reg_rdata_out,      // Read data, next cycle
  input  wire logic       pwr_up_req_in,      // Drivers requested on
  input  wire logic       sw_pd_in,           // Software power-down
  input  wire logic       amps_off_done_in,   // Amplifiers fully off
  output logic            dac_en_out,         // Converter power
  output logic            hp_en_out,          // Headphone driver power
  output logic            hp_ramp_step_out,   // One gain step pulse
  output logic            sp_en_out,          // Speaker amplifier power
  output logic            seq_busy_out,       // Sequence in progress
  output logic            dacl_to_mixer_out,  // Left converter to mixer
  output logic            dacl_to_hp_out,     // Left converter to driver
  output logic            voice_to_lmix_out,  // Voice input to left mixer
  output logic            extra_to_lmix_out,  // Line input to left mixer
  output logic            dacr_to_mixer_out,  // Right converter to mixer
  output logic            dacr_to_hp_out,     // Right converter to driver
  output logic            extra_to_rmix_out,  // Line input to right mixer
  output logic            hpl_to_hpr_out,     // Differential driver mode
  output logic            cm_from_supply_out  // Common mode from divider
);

  localparam int W = pop_seq_pkg::TMR_W;

  // ==========================================================================
  // Registers
  logic [7:0] hp_pop_q;
  logic [7:0] spk_wait_q;
  logic [7:0] mix_route_q;

  pop_seq_regs u_regs (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .hp_pop_out    (hp_pop_q),
    .spk_wait_out  (spk_wait_q),
    .mix_route_out (mix_route_q)
  );

  // Field extraction
  wire        pd_order   = hp_pop_q[pop_seq_pkg::PD_ORDER_BIT];
  wire [3:0]  pwron_code = hp_pop_q[pop_seq_pkg::PWRON_LSB +: pop_seq_pkg::PWRON_W];
  wire [1:0]  ramp_code  = hp_pop_q[pop_seq_pkg::RAMP_LSB +: pop_seq_pkg::RAMP_W];
  wire [2:0]  wait_code  = spk_wait_q[pop_seq_pkg::SPK_WAIT_LSB +: pop_seq_pkg::SPK_WAIT_W];
  wire [1:0]  dacl_code  = mix_route_q[pop_seq_pkg::DACL_LSB +: 2];
  wire [1:0]  dacr_code  = mix_route_q[pop_seq_pkg::DACR_LSB +: 2];

  // ==========================================================================
  // Oscillator tick, fractional divider of the system clock
  logic [31:0] osc_acc_q;
  logic        osc_tick_q;
  wire  [32:0] osc_sum = {1'b0, osc_acc_q} + 33'(OSC_HZ_P);
  wire         osc_wrap = osc_sum >= 33'(pop_seq_pkg::CLK_HZ);

  // Average rate is exact; single ticks jitter by one clock, far below a tick
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      osc_acc_q  <= 32'h0000_0000;
      osc_tick_q <= 1'b0;
    end else begin
      osc_acc_q  <= osc_wrap ? 32'(osc_sum - 33'(pop_seq_pkg::CLK_HZ)) : osc_sum[31:0];
      osc_tick_q <= osc_wrap;
    end
  end

  // ==========================================================================
  // Duration lookup
  function automatic logic [W-1:0] scale(input logic [W-1:0] t);
    logic [W-1:0] s;
    s = t / W'(TIME_DIV);
    return (t != '0 && s == '0) ? W'(1) : s;
  endfunction

  // Codes 1001 and above run the longest delay; 1100-1111 are never written
  function automatic logic [W-1:0] pwron_ticks(input logic [3:0] c);
    case (c)
      4'h0:    return '0;
      4'h1:    return pop_seq_pkg::PWRON_T1;
      4'h2:    return pop_seq_pkg::PWRON_T2;
      4'h3:    return pop_seq_pkg::PWRON_T3;
      4'h4:    return pop_seq_pkg::PWRON_T4;
      4'h5:    return pop_seq_pkg::PWRON_T5;
      4'h6:    return pop_seq_pkg::PWRON_T6;
      4'h7:    return pop_seq_pkg::PWRON_T7;
      4'h8:    return pop_seq_pkg::PWRON_T8;
      default: return pop_seq_pkg::PWRON_T9;
    endcase
  endfunction

  function automatic logic [W-1:0] ramp_ticks(input logic [1:0] c);
    case (c)
      2'h0:    return '0;
      2'h1:    return pop_seq_pkg::RAMP_T1;
      2'h2:    return pop_seq_pkg::RAMP_T2;
      default: return pop_seq_pkg::RAMP_T3;
    endcase
  endfunction

  function automatic logic [W-1:0] wait_ticks(input logic [2:0] c);
    case (c)
      3'h0:    return '0;
      3'h1:    return pop_seq_pkg::WAIT_T1;
      3'h2:    return pop_seq_pkg::WAIT_T2;
      3'h3:    return pop_seq_pkg::WAIT_T3;
      3'h4:    return pop_seq_pkg::WAIT_T4;
      3'h5:    return pop_seq_pkg::WAIT_T5;
      3'h6:    return pop_seq_pkg::WAIT_T6;
      default: return pop_seq_pkg::WAIT_T7;
    endcase
  endfunction

  wire [W-1:0] pwron_val = scale(pwron_ticks(pwron_code));
  wire [W-1:0] ramp_val  = scale(ramp_ticks(ramp_code));
  wire [W-1:0] wait_val  = scale(wait_ticks(wait_code));

  // ==========================================================================
  // Duration timer
  seq_timer_if #(.W(W)) tif ();

  seq_timer #(.W(W)) u_timer (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .tif     (tif)
  );

  // ==========================================================================
  // Sequencer
  pop_seq_pkg::seq_state_t state_q;
  pop_seq_pkg::seq_state_t state_d;
  logic [7:0]   step_q;
  logic [7:0]   step_d;
  logic         tmr_start;
  logic [W-1:0] tmr_load;
  logic         step_pulse;
  logic         dac_en_q;
  logic         hp_en_q;
  logic         sp_en_q;
  logic         step_pulse_q;

  wire pd_event = sw_pd_in || !pwr_up_req_in;
  wire last_step = step_q == 8'(RAMP_STEPS - 1);

  assign tif.start = tmr_start;
  assign tif.load  = tmr_load;
  assign tif.tick  = osc_tick_q;

  // Next state; a power-down aborts any stage of the power-up walk
  always_comb begin
    state_d    = state_q;
    step_d     = step_q;
    tmr_start  = 1'b0;
    tmr_load   = '0;
    step_pulse = 1'b0;
    case (state_q)
      pop_seq_pkg::SEQ_IDLE: begin
        if (pwr_up_req_in && !sw_pd_in) begin
          state_d   = pop_seq_pkg::SEQ_HP_PWRON;
          tmr_start = 1'b1;
          tmr_load  = pwron_val;
        end
      end
      pop_seq_pkg::SEQ_HP_PWRON: begin
        if (pd_event) begin
          state_d = pop_seq_pkg::SEQ_PD_AMPS;
        end else if (tif.done) begin
          state_d   = pop_seq_pkg::SEQ_HP_RAMP;
          step_d    = 8'h00;
          tmr_start = 1'b1;
          tmr_load  = ramp_val;
        end
      end
      pop_seq_pkg::SEQ_HP_RAMP: begin
        if (pd_event) begin
          state_d = pop_seq_pkg::SEQ_PD_AMPS;
        end else if (tif.done) begin
          step_pulse = 1'b1;
          tmr_start  = 1'b1;
          if (last_step) begin
            state_d  = pop_seq_pkg::SEQ_SPK_WAIT;
            tmr_load = wait_val;
          end else begin
            step_d   = step_q + 8'h01;
            tmr_load = ramp_val;
          end
        end
      end
      pop_seq_pkg::SEQ_SPK_WAIT: begin
        if (pd_event) begin
          state_d = pop_seq_pkg::SEQ_PD_AMPS;
        end else if (tif.done) begin
          state_d = pop_seq_pkg::SEQ_ON;
        end
      end
      pop_seq_pkg::SEQ_ON: begin
        if (pd_event) begin
          state_d = pop_seq_pkg::SEQ_PD_AMPS;
        end
      end
      pop_seq_pkg::SEQ_PD_AMPS: begin
        if (amps_off_done_in) begin
          state_d = pop_seq_pkg::SEQ_IDLE;
        end
      end
      default: state_d = pop_seq_pkg::SEQ_IDLE;
    endcase
  end

  // Power enables follow the next state so they switch on the same edge
  wire amps_on_d = (state_d != pop_seq_pkg::SEQ_IDLE) && (state_d != pop_seq_pkg::SEQ_PD_AMPS);
  wire sp_on_d   = state_d == pop_seq_pkg::SEQ_ON;
  // Ordered mode holds the converter until the amplifiers report off
  wire dac_on_d  = amps_on_d ||
                   (state_d == pop_seq_pkg::SEQ_PD_AMPS && pd_order);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q      <= pop_seq_pkg::SEQ_IDLE;
      step_q       <= 8'h00;
      dac_en_q     <= 1'b0;
      hp_en_q      <= 1'b0;
      sp_en_q      <= 1'b0;
      step_pulse_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      step_q       <= step_d;
      dac_en_q     <= dac_on_d;
      hp_en_q      <= amps_on_d;
      sp_en_q      <= sp_on_d;
      step_pulse_q <= step_pulse;
    end
  end

  assign dac_en_out       = dac_en_q;
  assign hp_en_out        = hp_en_q;
  assign sp_en_out        = sp_en_q;
  assign hp_ramp_step_out = step_pulse_q;
  assign seq_busy_out     = (state_q != pop_seq_pkg::SEQ_IDLE) && (state_q != pop_seq_pkg::SEQ_ON);

  // ==========================================================================
  // Routing selects, registered; reserved code 11 routes nowhere
  logic [8:0] route_q;
  wire  [8:0] route_d = {
    dacl_code == pop_seq_pkg::ROUTE_MIX,
    dacl_code == pop_seq_pkg::ROUTE_HP,
    mix_route_q[pop_seq_pkg::VOICE_L_BIT],
    mix_route_q[pop_seq_pkg::EXTRA_L_BIT],
    dacr_code == pop_seq_pkg::ROUTE_MIX,
    dacr_code == pop_seq_pkg::ROUTE_HP,
    mix_route_q[pop_seq_pkg::EXTRA_R_BIT],
    mix_route_q[pop_seq_pkg::DIFF_BIT],
    !hp_pop_q[pop_seq_pkg::CM_SRC_BIT]
  };

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      route_q <= 9'h001;
    end else begin
      route_q <= route_d;
    end
  end

  assign {dacl_to_mixer_out, dacl_to_hp_out, voice_to_lmix_out, extra_to_lmix_out,
          dacr_to_mixer_out, dacr_to_hp_out, extra_to_rmix_out, hpl_to_hpr_out,
          cm_from_supply_out} = route_q;

  // ==========================================================================
  // Checks
  sequence s_pd_request;
    state_q != pop_seq_pkg::SEQ_IDLE && state_q != pop_seq_pkg::SEQ_PD_AMPS && pd_event;
  endsequence

  a_dac_with_amps: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_pd_request ##0 !pd_order |=> !dac_en_out && !hp_en_out && !sp_en_out)
    else $error("converter not off with amplifiers");

  a_dac_after_amps: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_pd_request ##0 pd_order |=> !hp_en_out && !sp_en_out && dac_en_out)
    else $error("converter dropped before amplifiers were off");

  a_dac_hold_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_q == pop_seq_pkg::SEQ_PD_AMPS |=> dac_en_out == ($past(pd_order) && !$past(amps_off_done_in)))
    else $error("converter not held until amplifiers were off");

  a_pwron_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_q == pop_seq_pkg::SEQ_IDLE && pwr_up_req_in && !sw_pd_in
      |=> hp_en_out && (tif.busy == (pwron_ticks($past(pwron_code)) != '0)))
    else $error("power-on timer not started from code");

  a_reset_fields: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> pwron_code == 4'h7 && ramp_code == 2'h3 && wait_code == 3'h0)
    else $error("timing fields wrong after reset");

  a_ramp_reset: assert property (@(posedge clk_in)
    !rstn_in |=> ramp_val == scale(pop_seq_pkg::RAMP_T3) || !rstn_in)
    else $error("ramp step not longest after reset");

  a_wait_reset: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> wait_val == '0)
    else $error("speaker wait not zero after reset");

  a_osc_rate: assert property (@(posedge clk_in) disable iff (!rstn_in)
    osc_tick_q |=> !osc_tick_q [*8])
    else $error("oscillator ticks too close together");

  a_sp_after_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(sp_en_out) |-> $past(state_q) == pop_seq_pkg::SEQ_SPK_WAIT && $past(tif.done))
    else $error("speaker enabled without its wait");

  a_route_left: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(dacl_to_mixer_out && dacl_to_hp_out) && (dacl_to_hp_out == ($past(dacl_code) == 2'h2)))
    else $error("left converter route wrong");

  a_route_right: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(dacr_to_mixer_out && dacr_to_hp_out) && (dacr_to_mixer_out == ($past(dacr_code) == 2'h1)))
    else $error("right converter route wrong");

  a_route_inputs: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ##1 voice_to_lmix_out == $past(mix_route_q[5]) && extra_to_lmix_out == $past(mix_route_q[4]))
    else $error("left mixer input route wrong");

  a_route_right_in: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ##1 extra_to_rmix_out == $past(mix_route_q[1]) && hpl_to_hpr_out == $past(mix_route_q[0]))
    else $error("right input or differential route wrong");

  a_cm_source: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ##1 cm_from_supply_out != $past(hp_pop_q[0]))
    else $error("common-mode source wrong");

endmodule

// ---- pop_seq_pkg.sv ----
package pop_seq_pkg;

  // ==========================================================================
  // Register map (page 1)
  localparam logic [7:0] HP_POP_OFS    = 8'h21;
  localparam logic [7:0] SPK_WAIT_OFS  = 8'h22;
  localparam logic [7:0] MIX_ROUTE_OFS = 8'h23;
  localparam logic [7:0] HP_POP_RST    = 8'h3e;
  localparam logic [7:0] SPK_WAIT_RST  = 8'h00;
  localparam logic [7:0] MIX_ROUTE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD   = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int PD_ORDER_BIT  = 7;
  localparam int PWRON_LSB     = 3;
  localparam int PWRON_W       = 4;
  localparam int RAMP_LSB      = 1;
  localparam int RAMP_W        = 2;
  localparam int CM_SRC_BIT    = 0;
  localparam int SPK_WAIT_LSB  = 4;
  localparam int SPK_WAIT_W    = 3;
  localparam int DACL_LSB      = 6;
  localparam int VOICE_L_BIT   = 5;
  localparam int EXTRA_L_BIT   = 4;
  localparam int DACR_LSB      = 2;
  localparam int EXTRA_R_BIT   = 1;
  localparam int DIFF_BIT      = 0;

  localparam logic [1:0] ROUTE_MIX = 2'h1;
  localparam logic [1:0] ROUTE_HP  = 2'h2;

  // ==========================================================================
  // Timing: oscillator rate and nominal durations in ns
  localparam int unsigned CLK_HZ  = 200_000_000;
  localparam longint      OSC_HZ  = 64'd8_200_000;
  localparam longint      NS_PER_S = 64'd1_000_000_000;
  localparam int          TMR_W   = 26;

  // Least times round up to whole oscillator ticks
  function automatic logic [TMR_W-1:0] ns_to_ticks(input longint ns);
    return TMR_W'((ns * OSC_HZ + NS_PER_S - 64'd1) / NS_PER_S);
  endfunction

  localparam logic [TMR_W-1:0] PWRON_T1 = ns_to_ticks(64'd15_300);
  localparam logic [TMR_W-1:0] PWRON_T2 = ns_to_ticks(64'd153_000);
  localparam logic [TMR_W-1:0] PWRON_T3 = ns_to_ticks(64'd1_530_000);
  localparam logic [TMR_W-1:0] PWRON_T4 = ns_to_ticks(64'd15_300_000);
  localparam logic [TMR_W-1:0] PWRON_T5 = ns_to_ticks(64'd76_200_000);
  localparam logic [TMR_W-1:0] PWRON_T6 = ns_to_ticks(64'd153_000_000);
  localparam logic [TMR_W-1:0] PWRON_T7 = ns_to_ticks(64'd304_000_000);
  localparam logic [TMR_W-1:0] PWRON_T8 = ns_to_ticks(64'd610_000_000);
  localparam logic [TMR_W-1:0] PWRON_T9 = ns_to_ticks(64'd6_100_000_000);
  localparam logic [TMR_W-1:0] RAMP_T1  = ns_to_ticks(64'd980_000);
  localparam logic [TMR_W-1:0] RAMP_T2  = ns_to_ticks(64'd1_950_000);
  localparam logic [TMR_W-1:0] RAMP_T3  = ns_to_ticks(64'd3_900_000);
  localparam logic [TMR_W-1:0] WAIT_T1  = ns_to_ticks(64'd3_040_000);
  localparam logic [TMR_W-1:0] WAIT_T2  = ns_to_ticks(64'd7_620_000);
  localparam logic [TMR_W-1:0] WAIT_T3  = ns_to_ticks(64'd12_200_000);
  localparam logic [TMR_W-1:0] WAIT_T4  = ns_to_ticks(64'd15_300_000);
  localparam logic [TMR_W-1:0] WAIT_T5  = ns_to_ticks(64'd19_800_000);
  localparam logic [TMR_W-1:0] WAIT_T6  = ns_to_ticks(64'd24_400_000);
  localparam logic [TMR_W-1:0] WAIT_T7  = ns_to_ticks(64'd30_500_000);

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_HP_PWRON, SEQ_HP_RAMP, SEQ_SPK_WAIT, SEQ_ON, SEQ_PD_AMPS
  } seq_state_t;

endpackage

// ---- seq_timer_if.sv ----
`timescale 1ns/10ps
interface seq_timer_if #(parameter int W = 26);
  logic         start;  // Load and run
  logic [W-1:0] load;   // Ticks to count
  logic         tick;   // Oscillator enable
  logic         done;   // One-cycle end pulse
  logic         busy;   // Counting
  modport ctl (output start, load, tick, input done, busy);
  modport tmr (input start, load, tick, output done, busy);
endinterface

// ---- seq_timer.sv ----
`timescale 1ns/10ps
module seq_timer #(
  parameter int W = 26
) (
  input  wire logic  clk_in,   // System clock
  input  wire logic  rstn_in,  // Async reset, active low
  seq_timer_if.tmr   tif       // Control side
);

  logic [W-1:0] count_q;
  logic         busy_q;
  logic         done_q;
  logic         last_tick;

  // Final tick of a nonzero load
  assign last_tick = busy_q && tif.tick && (count_q == W'(1));
  assign tif.done  = done_q;
  assign tif.busy  = busy_q;

  // Reload on every start, so a new step always restarts cleanly
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_q <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (tif.start) begin
      count_q <= tif.load;
      busy_q  <= (tif.load != '0);
      done_q  <= (tif.load == '0);
    end else begin
      count_q <= (busy_q && tif.tick) ? count_q - W'(1) : count_q;
      busy_q  <= busy_q && !last_tick;
      done_q  <= last_tick;
    end
  end

  a_timer_done_end: assert property (@(posedge clk_in) disable iff (!rstn_in)
    last_tick && !tif.start |=> tif.done && !tif.busy)
    else $error("timer did not finish on its last tick");

endmodule

// ---- pop_seq_regs.sv ----
`timescale 1ns/10ps
module pop_seq_regs (
  input  wire logic       clk_in,         // System clock
  input  wire logic       rstn_in,        // Async reset, active low
  input  wire logic [7:0] reg_addr_in,    // Offset
  input  wire logic [7:0] reg_wdata_in,   // Write data
  input  wire logic       reg_wr_in,      // Write strobe
  input  wire logic       reg_rd_in,      // Read strobe
  output logic      [7:0] reg_rdata_out,  // Registered read data
  output logic      [7:0] hp_pop_out,     // Pop-removal control
  output logic      [7:0] spk_wait_out,   // Speaker wait / ramp-down
  output logic      [7:0] mix_route_out   // Mixer routing
);

  logic [7:0] hp_pop_q;
  logic [7:0] spk_wait_q;
  logic [7:0] mix_route_q;
  logic [7:0] rdata_q;

  // Address decode
  wire sel_pop   = reg_addr_in == pop_seq_pkg::HP_POP_OFS;
  wire sel_wait  = reg_addr_in == pop_seq_pkg::SPK_WAIT_OFS;
  wire sel_route = reg_addr_in == pop_seq_pkg::MIX_ROUTE_OFS;
  wire [7:0] rd_mux = sel_pop   ? hp_pop_q :
                      sel_wait  ? spk_wait_q :
                      sel_route ? mix_route_q : pop_seq_pkg::UNMAPPED_RD;

  // Reserved bits are stored as written; software keeps them at reset value
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hp_pop_q    <= pop_seq_pkg::HP_POP_RST;
      spk_wait_q  <= pop_seq_pkg::SPK_WAIT_RST;
      mix_route_q <= pop_seq_pkg::MIX_ROUTE_RST;
      rdata_q     <= 8'h00;
    end else begin
      if (reg_wr_in && sel_pop)   hp_pop_q    <= reg_wdata_in;
      if (reg_wr_in && sel_wait)  spk_wait_q  <= reg_wdata_in;
      if (reg_wr_in && sel_route) mix_route_q <= reg_wdata_in;
      if (reg_rd_in)              rdata_q     <= rd_mux;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign hp_pop_out    = hp_pop_q;
  assign spk_wait_out  = spk_wait_q;
  assign mix_route_out = mix_route_q;

endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // ==========================================
  // Bench signals
  logic       clk_in = 1'b0;       // 200 MHz clock
  logic       rstn_in = 1'b0;      // Reset, active low
  logic [7:0] addr = 8'h00;        // Register offset
  logic [7:0] wdata = 8'h00;       // Write data
  logic [7:0] rdata, r;            // Read data, random route
  logic       wr = 1'b0, rd = 1'b0, req = 1'b0, pd = 1'b0, aoff = 1'b0;
  logic       dac, hp, step, sp, busy, cm;
  wire  [7:0] route;               // Routing outputs, msb first
  int         fail_count = 0, n_checks = 0, nstep = 0, i, k;
  logic [7:0] cfg_hp[2] = '{8'h00, 8'h9a};
  logic [7:0] cfg_wt[2] = '{8'h00, 8'h10};
  int         lo[2] = '{0, 2200};
  int         hi[2] = '{60, 2700};

  // Clock; division by 1000 keeps the timed stages short
  always #2.5 clk_in = ~clk_in;
  pop_seq #(.TIME_DIV(1000)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .pwr_up_req_in(req), .sw_pd_in(pd),
    .amps_off_done_in(aoff), .dac_en_out(dac), .hp_en_out(hp),
    .hp_ramp_step_out(step), .sp_en_out(sp), .seq_busy_out(busy),
    .dacl_to_mixer_out(route[7]), .dacl_to_hp_out(route[6]),
    .voice_to_lmix_out(route[5]), .extra_to_lmix_out(route[4]),
    .dacr_to_mixer_out(route[3]), .dacr_to_hp_out(route[2]),
    .extra_to_rmix_out(route[1]), .hpl_to_hpr_out(route[0]),
    .cm_from_supply_out(cm));

  // Count gain steps seen on the pulse output
  // Sampled mid-cycle, where the registered pulse is settled
  always @(negedge clk_in) if (step === 1'b1) nstep++;

  // ==========================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 addr = a; wdata = d; wr = 1'b1;
    @(posedge clk_in);
    #1 wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    #1 addr = a; rd = 1'b1;
    @(posedge clk_in);
    #1 rd = 1'b0;
    chk(rdata, e);
  endtask
  // Expected routing decode from a register value
  function automatic logic [7:0] route_exp(input logic [7:0] v);
    return {v[7:6] == 2'h1, v[7:6] == 2'h2, v[5], v[4],
            v[3:2] == 2'h1, v[3:2] == 2'h2, v[1], v[0]};
  endfunction
  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    k = $urandom(7);
    repeat (12) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    chk({7'h00, cm}, 8'h01);
    rd_chk(8'h21, 8'h3e);
    rd_chk(8'h22, 8'h00);
    rd_chk(8'h23, 8'h00);
    wr_reg(8'h24, 8'h5a);
    rd_chk(8'h24, 8'h00);
    rd_chk(8'h21, 8'h3e);
    // Random routing, reserved route codes avoided
    for (i = 0; i < 24; i++) begin
      r = 8'($urandom);
      if (r[7:6] == 2'h3) r[7] = 1'b0;
      if (r[3:2] == 2'h3) r[3] = 1'b0;
      wr_reg(8'h23, r);
      @(posedge clk_in);
      #1 chk(route, route_exp(r));
    end
    // Power-up then power-down, order bit 0 then 1
    for (k = 0; k < 2; k++) begin
      wr_reg(8'h21, cfg_hp[k]);
      wr_reg(8'h22, cfg_wt[k]);
      nstep = 0;
      @(posedge clk_in);
      #1 req = 1'b1;
      for (i = 0; i < 4000 && sp !== 1'b1; i++) begin
        @(posedge clk_in);
        #1;
      end
      if (i == 4000) begin
        fail_count++;
        break;
      end
      chk({7'h00, i >= lo[k] && i <= hi[k]}, 8'h01);
      chk(8'(nstep), 8'h08);
      chk({5'h00, cm, dac, hp}, 8'h07);
      pd = 1'b1;
      @(posedge clk_in);
      #1 chk({5'h00, dac, hp, sp}, {5'h00, k[0], 2'h0});
      repeat (3) @(posedge clk_in);
      #1 chk({6'h00, dac, busy}, {6'h00, k[0], 1'b1});
      aoff = 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk({6'h00, dac, busy}, 8'h00);
      pd = 1'b0;
      req = 1'b0;
      aoff = 1'b0;
    end
    complete_run();
  end
endmodule
